// file: hdl/paf_pad_ctl.sv
`timescale 1ns/1ns
// one pin: pick each pad control from override or port register; input enable is override or one
module paf_pad_ctl (
  input  wire logic i_ref_clk,
  input  wire logic i_reset,
  input  wire logic i_dir_bit,
  input  wire logic i_out_bit,
  input  wire logic i_pullup_disable,
  input  wire logic i_pullup_override_enable,
  input  wire logic i_pullup_override_value,
  input  wire logic i_direction_override_enable,
  input  wire logic i_direction_override_value,
  input  wire logic i_output_value_override_enable,
  input  wire logic i_output_value_override_value,
  input  wire logic i_tristate_override_enable,
  input  wire logic i_input_enable_override_enable,
  input  wire logic i_input_enable_override_value,
  output logic      o_pullup,
  output logic      o_drive_en,
  output logic      o_drive_val,
  output logic      o_input_en
);
  import paf_pkg::*;
  logic dir;
  logic val;
  logic pu;
  logic ie;

  always_comb begin
    dir = i_direction_override_enable ? i_direction_override_value : i_dir_bit;
    val = i_output_value_override_enable ? i_output_value_override_value : i_out_bit;
    // normal pull-up: input, port bit one, not disabled
    pu  = i_pullup_override_enable ? i_pullup_override_value
                 : (~i_dir_bit & i_out_bit & ~i_pullup_disable);
    ie  = i_input_enable_override_enable ? i_input_enable_override_value : 1'b1;
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_pullup    <= PAF_RST_BIT;
      o_drive_en  <= PAF_RST_BIT;
      o_drive_val <= PAF_RST_BIT;
      o_input_en  <= PAF_RST_BIT;
    end else begin
      // tristate override releases the driver only while the output value is one, so an open drain works
      o_drive_en  <= dir & ~(i_tristate_override_enable & val);
      o_drive_val <= val;
      o_pullup    <= pu & ~dir;
      o_input_en  <= ie;
    end
  end
endmodule

// file: hdl/paf_port_a.sv
`timescale 1ns/1ns
module paf_port_a (
  input  wire logic                          i_ref_clk,
  input  wire logic                          i_reset,
  input  wire logic [paf_pkg::PAF_PINS-1:0]  i_direction_bits,
  input  wire logic [paf_pkg::PAF_PINS-1:0]  i_output_bits,
  input  wire logic                          i_global_pullup_disable,
  input  wire logic                          i_port_pullup_disable,
  input  wire logic                          i_spi_enable_bit,
  input  wire logic                          i_spi_master_select,
  input  wire logic                          i_spi_slave_data_out,
  input  wire logic                          i_spi_master_data_out,
  input  wire logic                          i_spi_clock_out,
  input  wire logic                          i_serial_if_pin_position_select,
  input  wire logic                          i_serial_if_two_wire_mode,
  input  wire logic                          i_serial_if_three_wire_mode,
  input  wire logic                          i_serial_if_shift_output,
  input  wire logic                          i_serial_if_start_irq_enable,
  input  wire logic                          i_serial_if_tristate_override,
  input  wire logic                          i_serial_if_clock_hold,
  input  wire logic                          i_uart_rx_enable,
  input  wire logic                          i_uart_tx_enable,
  input  wire logic                          i_lin_rx_enable,
  input  wire logic                          i_lin_tx_enable,
  input  wire logic                          i_lin_tx_bit,
  input  wire logic                          i_timer0_compare_a_enable,
  input  wire logic                          i_timer0_compare_a_output,
  input  wire logic                          i_ext_irq1_enable,
  input  wire logic                          i_port_change_irq_enable,
  input  wire logic [paf_pkg::PAF_PINS-1:0]  i_change_mask_bits,
  input  wire logic [paf_pkg::PAF_PINS-1:0]  i_analog_input_disable,
  input  wire logic [paf_pkg::PAF_PINS-1:0]  i_pad_in,
  output logic      [paf_pkg::PAF_PINS-1:0]  o_pad_pullup,
  output logic      [paf_pkg::PAF_PINS-1:0]  o_pad_drive_en,
  output logic      [paf_pkg::PAF_PINS-1:0]  o_pad_drive_val,
  output logic      [paf_pkg::PAF_PINS-1:0]  o_pad_input_en,
  output logic      [paf_pkg::PAF_PINS-1:0]  o_pin_change_sources,
  output logic                               o_timer1_external_clock,
  output logic                               o_timer1_capture_trigger,
  output logic                               o_serial_if_clock_in,
  output logic                               o_serial_if_data_in,
  output logic                               o_spi_clock_in,
  output logic                               o_spi_slave_data_in,
  output logic                               o_spi_master_data_in,
  output logic                               o_spi_slave_select_in,
  output logic                               o_ext_irq1_in
);
  import paf_pkg::*;

  localparam int N = PAF_PINS;

  // the override tables below are written for exactly eight pins
  if (N != 8) begin : g_bad_pins
    $error("paf_port_a: the override logic serves eight pins only");
  end

  logic [N-1:0] pullup_override_enable, pullup_override_value, direction_override_enable, direction_override_value, output_value_override_enable, output_value_override_value, tristate_override_enable, input_enable_override_enable, input_enable_override_value;
  logic [N-1:0] pin_sync;
  logic [N-1:0] din_gated;
  logic         global_pullup_disable;
  logic         spi_m;
  logic         tw_pos;
  logic         usi_out;
  logic [N-1:0] chg;
  logic         rx_force;
  logic         tx_force;

  assign global_pullup_disable      = i_global_pullup_disable | i_port_pullup_disable;
  assign spi_m    = i_spi_enable_bit & i_spi_master_select;
  assign tw_pos   = i_serial_if_two_wire_mode &
                    i_serial_if_pin_position_select;
  assign usi_out  = tw_pos & i_serial_if_three_wire_mode;
  assign chg      = {N{i_port_change_irq_enable}} & i_change_mask_bits;
  assign rx_force = i_lin_rx_enable | i_uart_rx_enable;
  assign tx_force = i_lin_tx_enable | i_uart_tx_enable;

  always_comb begin
    // pin 0: receive input, forced to input by either receiver
    pullup_override_enable[0]  = rx_force;
    pullup_override_value[0]  = i_output_bits[0] & ~global_pullup_disable;
    direction_override_enable[0]  = rx_force;
    direction_override_value[0]  = 1'b0;
    output_value_override_enable[0]  = 1'b0;
    output_value_override_value[0]  = 1'b0;
    tristate_override_enable[0]  = 1'b0;
    input_enable_override_enable[0] = i_analog_input_disable[0] | chg[0];
    input_enable_override_value[0] = chg[0];
    // pin 1: transmit output
    pullup_override_enable[1]  = tx_force;
    pullup_override_value[1]  = i_lin_tx_enable ? 1'b0
                               : (i_output_bits[1] & ~global_pullup_disable);
    direction_override_enable[1]  = tx_force;
    direction_override_value[1]  = tx_force;
    output_value_override_enable[1]  = i_lin_tx_enable;
    output_value_override_value[1]  = i_lin_tx_enable ? i_lin_tx_bit : 1'b0;
    tristate_override_enable[1]  = 1'b0;
    input_enable_override_enable[1] = i_analog_input_disable[1] | chg[1];
    input_enable_override_value[1] = chg[1];
    // pin 2: SPI slave data, shift output, compare A
    pullup_override_enable[2]  = spi_m;
    pullup_override_value[2]  = i_output_bits[2] & ~global_pullup_disable;
    direction_override_enable[2]  = spi_m;
    direction_override_value[2]  = 1'b0;
    output_value_override_enable[2]  = spi_m | usi_out | i_timer0_compare_a_enable;
    if (spi_m) begin
      output_value_override_value[2] = i_spi_slave_data_out;
    end else if (usi_out) begin
      output_value_override_value[2] = i_serial_if_shift_output;
    end else begin
      output_value_override_value[2] = i_timer0_compare_a_output;
    end
    tristate_override_enable[2]  = 1'b0;
    input_enable_override_enable[2] = i_analog_input_disable[2] | chg[2];
    input_enable_override_value[2] = chg[2];
    // pin 3: only the input enable is touched
    pullup_override_enable[3]  = 1'b0;
    pullup_override_value[3]  = 1'b0;
    direction_override_enable[3]  = 1'b0;
    direction_override_value[3]  = 1'b0;
    output_value_override_enable[3]  = 1'b0;
    output_value_override_value[3]  = 1'b0;
    tristate_override_enable[3]  = 1'b0;
    input_enable_override_enable[3] = i_analog_input_disable[3] | i_ext_irq1_enable | chg[3];
    input_enable_override_value[3] = i_ext_irq1_enable | chg[3];
    // pin 4: SPI master data, two-wire data
    pullup_override_enable[4]  = spi_m;
    pullup_override_value[4]  = i_output_bits[4] & ~global_pullup_disable;
    direction_override_enable[4]  = spi_m | tw_pos;
    direction_override_value[4]  = spi_m ? 1'b1 : i_direction_bits[4];
    output_value_override_enable[4]  = spi_m | (tw_pos & i_direction_bits[4]);
    output_value_override_value[4]  = spi_m ? i_spi_master_data_out
                     : ~(tw_pos & i_direction_bits[4]);
    tristate_override_enable[4]  = 1'b0;
    input_enable_override_enable[4] = i_analog_input_disable[4] |
               (i_serial_if_start_irq_enable &
                i_serial_if_pin_position_select) | chg[4];
    input_enable_override_value[4] = (i_serial_if_start_irq_enable &
                i_serial_if_pin_position_select) | chg[4];
    // pin 5: SPI clock, two-wire clock
    pullup_override_enable[5]  = spi_m;
    pullup_override_value[5]  = i_output_bits[5] & ~global_pullup_disable;
    direction_override_enable[5]  = spi_m | tw_pos;
    direction_override_value[5]  = (i_serial_if_clock_hold | i_output_bits[5]) &
               i_direction_bits[6];
    output_value_override_enable[5]  = spi_m | (tw_pos & i_direction_bits[5]);
    output_value_override_value[5]  = spi_m ? i_spi_clock_out
                     : ~(tw_pos & i_direction_bits[5]);
    tristate_override_enable[5]  = i_serial_if_tristate_override &
               i_serial_if_pin_position_select;
    input_enable_override_enable[5] = i_analog_input_disable[5] |
               (i_serial_if_start_irq_enable &
                i_serial_if_pin_position_select) | chg[5];
    input_enable_override_value[5] = (i_serial_if_start_irq_enable &
                i_serial_if_pin_position_select) | chg[5];
    // pin 6: slave select, input in SPI master mode
    pullup_override_enable[6]  = spi_m;
    pullup_override_value[6]  = i_output_bits[6] & ~global_pullup_disable;
    direction_override_enable[6]  = spi_m;
    direction_override_value[6]  = 1'b0;
    output_value_override_enable[6]  = 1'b0;
    output_value_override_value[6]  = 1'b0;
    tristate_override_enable[6]  = 1'b0;
    input_enable_override_enable[6] = i_analog_input_disable[6] | chg[6];
    input_enable_override_value[6] = chg[6];
    // pin 7: reference pin, only input enable
    pullup_override_enable[7]  = 1'b0;
    pullup_override_value[7]  = 1'b0;
    direction_override_enable[7]  = 1'b0;
    direction_override_value[7]  = 1'b0;
    output_value_override_enable[7]  = 1'b0;
    output_value_override_value[7]  = 1'b0;
    tristate_override_enable[7]  = 1'b0;
    input_enable_override_enable[7] = i_analog_input_disable[7] | chg[7];
    input_enable_override_value[7] = chg[7];
  end

  for (genvar p = 0; p < N; p++) begin : g_pin
    paf_pad_ctl u_pad (
      .i_ref_clk        (i_ref_clk),
      .i_reset          (i_reset),
      .i_dir_bit        (i_direction_bits[p]),
      .i_out_bit        (i_output_bits[p]),
      .i_pullup_disable (global_pullup_disable),
      .i_pullup_override_enable           (pullup_override_enable[p]),
      .i_pullup_override_value           (pullup_override_value[p]),
      .i_direction_override_enable           (direction_override_enable[p]),
      .i_direction_override_value           (direction_override_value[p]),
      .i_output_value_override_enable           (output_value_override_enable[p]),
      .i_output_value_override_value           (output_value_override_value[p]),
      .i_tristate_override_enable           (tristate_override_enable[p]),
      .i_input_enable_override_enable          (input_enable_override_enable[p]),
      .i_input_enable_override_value          (input_enable_override_value[p]),
      .o_pullup         (o_pad_pullup[p]),
      .o_drive_en       (o_pad_drive_en[p]),
      .o_drive_val      (o_pad_drive_val[p]),
      .o_input_en       (o_pad_input_en[p])
    );
  end

  paf_sync #(
    .WIDTH (N)
  ) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_async   (i_pad_in),
    .o_sync    (pin_sync)
  );

  // disabled digital input reads as zero
  assign din_gated = pin_sync & o_pad_input_en;

  // every pin feeds its own pin-change source
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_pin_change_sources <= PAF_RST_BYTE;
    end else begin
      o_pin_change_sources <= din_gated;
    end
  end

  // pin 5 is the shared clock input
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_timer1_external_clock <= PAF_RST_BIT;
      o_serial_if_clock_in    <= PAF_RST_BIT;
      o_spi_clock_in          <= PAF_RST_BIT;
    end else begin
      o_timer1_external_clock <= din_gated[PAF_SCK_PIN];
      o_serial_if_clock_in    <= din_gated[PAF_SCK_PIN];
      o_spi_clock_in          <= din_gated[PAF_SCK_PIN];
    end
  end

  // pin 4 is the shared data and capture input
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_timer1_capture_trigger <= PAF_RST_BIT;
      o_serial_if_data_in      <= PAF_RST_BIT;
      o_spi_slave_data_in      <= PAF_RST_BIT;
    end else begin
      o_timer1_capture_trigger <= din_gated[PAF_MOSI_PIN];
      o_serial_if_data_in      <= din_gated[PAF_MOSI_PIN];
      o_spi_slave_data_in      <= din_gated[PAF_MOSI_PIN];
    end
  end

  // pin 2 carries the receive data of the SPI master
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_spi_master_data_in <= PAF_RST_BIT;
    end else begin
      o_spi_master_data_in <= din_gated[PAF_MISO_PIN];
    end
  end

  // pin 6 is the SPI slave select
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_spi_slave_select_in <= PAF_RST_BIT;
    end else begin
      o_spi_slave_select_in <= din_gated[PAF_SS_PIN];
    end
  end

  // pin 3 is external interrupt 1
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_ext_irq1_in <= PAF_RST_BIT;
    end else begin
      o_ext_irq1_in <= din_gated[PAF_INT1_PIN];
    end
  end
endmodule

// file: hdl/paf_sync.sv
`timescale 1ns/1ns
// two-stage synchroniser for a bank of pad inputs
module paf_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_reset,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  import paf_pkg::*;
  logic [WIDTH-1:0] meta_reg;

  if (WIDTH < 1) begin : g_bad_width
    $error("paf_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      meta_reg <= '0;
      o_sync   <= '0;
    end else begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end
endmodule

// file: pkg/paf_pkg.sv
package paf_pkg;
  localparam int PAF_PINS      = 8;
  localparam int PAF_SYNC_LEN  = 2;
  localparam logic [7:0] PAF_RST_BYTE = 8'h00;
  localparam logic       PAF_RST_BIT  = 1'b0;
  localparam int PAF_RX_PIN    = 0;
  localparam int PAF_TX_PIN    = 1;
  localparam int PAF_MISO_PIN  = 2;
  localparam int PAF_INT1_PIN  = 3;
  localparam int PAF_MOSI_PIN  = 4;
  localparam int PAF_SCK_PIN   = 5;
  localparam int PAF_SS_PIN    = 6;
  localparam int PAF_AREF_PIN  = 7;
endpackage

// file: sim/paf_pad_model.sv
`timescale 1ns/1ns
module paf_pad_model (
  input  wire logic       i_ref_clk,
  input  wire logic [7:0] i_drive_en,
  input  wire logic [7:0] i_drive_val,
  input  wire logic [7:0] i_pullup,
  input  wire logic [7:0] i_ext_en,
  input  wire logic [7:0] i_ext_val,
  output logic      [7:0] o_pad
);
  logic [7:0] float_reg = 8'h00;
  // a released line with no pull-up drifts: it flips every cycle
  always_ff @(posedge i_ref_clk) begin
    float_reg <= ~float_reg;
  end
  assign o_pad = i_drive_en & i_drive_val | ~i_drive_en &
    (i_ext_en & i_ext_val | ~i_ext_en & (i_pullup | float_reg));
endmodule

// file: sim/paf_port_a_checker.sv
`timescale 1ns/1ns
module paf_port_a_checker (
  input wire logic       i_ref_clk,
  input wire logic       i_reset,
  input wire logic [7:0] i_direction_bits,
  input wire logic [7:0] i_output_bits,
  input wire logic       i_global_pullup_disable,
  input wire logic       i_port_pullup_disable,
  input wire logic       i_spi_enable_bit,
  input wire logic       i_spi_master_select,
  input wire logic       i_spi_master_data_out,
  input wire logic       i_uart_rx_enable,
  input wire logic       i_uart_tx_enable,
  input wire logic       i_lin_rx_enable,
  input wire logic       i_lin_tx_enable,
  input wire logic       i_lin_tx_bit,
  input wire logic       i_port_change_irq_enable,
  input wire logic [7:0] i_change_mask_bits,
  input wire logic [7:0] i_analog_input_disable,
  input wire logic [7:0] o_pad_pullup,
  input wire logic [7:0] o_pad_drive_en,
  input wire logic [7:0] o_pad_drive_val,
  input wire logic [7:0] o_pad_input_en
);
  wire sm = i_spi_enable_bit & i_spi_master_select;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  chk_rx_in_dir: assert property (
    i_uart_rx_enable | i_lin_rx_enable |=> !o_pad_drive_en[0])
    else $error("pin 0 driven while receiving");
  chk_tx_out_dir: assert property (
    i_uart_tx_enable | i_lin_tx_enable |=> o_pad_drive_en[1])
    else $error("pin 1 not driven while sending");
  chk_lin_tx_val: assert property (i_lin_tx_enable
    |=> o_pad_drive_val[1] == $past(i_lin_tx_bit)) else $error("pin 1 value");
  chk_quiet_pins: assert property (1'b1 |=>
    {o_pad_drive_en & 8'h88, o_pad_drive_val & 8'h88} ==
    {$past(i_direction_bits) & 8'h88, $past(i_output_bits) & 8'h88})
    else $error("pin 3/7");
  chk_mosi_drive: assert property (sm |=> o_pad_drive_en[4] &&
    o_pad_drive_val[4] == $past(i_spi_master_data_out)) else $error("pin 4");
  chk_ss_input: assert property (sm |=> !o_pad_drive_en[6])
    else $error("pin 6 driven in master mode");
  chk_pullup_off: assert property (i_global_pullup_disable |
    i_port_pullup_disable |=> o_pad_pullup == 8'h00) else $error("pull-up on");
  chk_edge_ien: assert property (1'b1 |=>
    (o_pad_input_en & 8'h81) == ((~$past(i_analog_input_disable) |
    ($past(i_change_mask_bits) & {8{$past(i_port_change_irq_enable)}}))
    & 8'h81)) else $error("pin 0/7 ien");
endmodule
bind paf_port_a paf_port_a_checker u_chk (.i_ref_clk(i_ref_clk),
  .i_reset(i_reset), .i_direction_bits(i_direction_bits),
  .i_output_bits(i_output_bits), .i_spi_enable_bit(i_spi_enable_bit),
  .i_global_pullup_disable(i_global_pullup_disable),
  .i_port_pullup_disable(i_port_pullup_disable),
  .i_spi_master_select(i_spi_master_select), .i_lin_tx_bit(i_lin_tx_bit),
  .i_spi_master_data_out(i_spi_master_data_out),
  .i_uart_rx_enable(i_uart_rx_enable), .i_uart_tx_enable(i_uart_tx_enable),
  .i_lin_rx_enable(i_lin_rx_enable), .i_lin_tx_enable(i_lin_tx_enable),
  .i_port_change_irq_enable(i_port_change_irq_enable),
  .i_change_mask_bits(i_change_mask_bits), .o_pad_pullup(o_pad_pullup),
  .i_analog_input_disable(i_analog_input_disable),
  .o_pad_drive_en(o_pad_drive_en), .o_pad_drive_val(o_pad_drive_val),
  .o_pad_input_en(o_pad_input_en));

// file: sim/testbench.sv
`timescale 1ns/1ns
module testbench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  dir = 8'h00, outb = 8'h00, msk = 8'h00, adc = 8'h00;
  logic [7:0]  xe = 8'h00, xv = 8'h00;
  logic [22:0] c = 23'h000000;
  logic [7:0]  de, dv, pu, ie, pcs, pad, ed, ev, epu, ien, pe, km;
  logic [8:0]  sp;
  int          failures = 0, check_count = 0, cyc = 0, t;
  initial forever #4 clk = ~clk;
  // c: 0 gpud 1 ppud 2 spe 3 spi_master_select 4 miso 5 mosi 6 sck 7 pos 8 2w 9 3w
  // 10 shift 11 sie 12 tristate_override_enable 13 hold 14 urx 15 utx 16 lrx 17 ltx 18 txb
  // 19 timer0_compare_a_output en 20 timer0_compare_a_output 21 int1 en 22 pcie
  paf_port_a u_paf_port_a (.i_ref_clk(clk), .i_reset(rst),
    .i_direction_bits(dir), .i_output_bits(outb),
    .i_global_pullup_disable(c[0]), .i_port_pullup_disable(c[1]),
    .i_spi_enable_bit(c[2]), .i_spi_master_select(c[3]),
    .i_spi_slave_data_out(c[4]), .i_spi_master_data_out(c[5]),
    .i_spi_clock_out(c[6]), .i_serial_if_pin_position_select(c[7]),
    .i_serial_if_two_wire_mode(c[8]), .i_serial_if_three_wire_mode(c[9]),
    .i_serial_if_shift_output(c[10]), .i_serial_if_start_irq_enable(c[11]),
    .i_serial_if_tristate_override(c[12]), .i_serial_if_clock_hold(c[13]),
    .i_uart_rx_enable(c[14]), .i_uart_tx_enable(c[15]),
    .i_lin_rx_enable(c[16]), .i_lin_tx_enable(c[17]), .i_lin_tx_bit(c[18]),
    .i_timer0_compare_a_enable(c[19]), .i_timer0_compare_a_output(c[20]),
    .i_ext_irq1_enable(c[21]), .i_port_change_irq_enable(c[22]),
    .i_change_mask_bits(msk), .i_analog_input_disable(adc), .i_pad_in(pad),
    .o_pad_pullup(pu), .o_pad_drive_en(de), .o_pad_drive_val(dv),
    .o_pad_input_en(ie), .o_pin_change_sources(pcs),
    .o_timer1_external_clock(sp[0]), .o_timer1_capture_trigger(sp[1]),
    .o_serial_if_clock_in(sp[2]), .o_serial_if_data_in(sp[3]),
    .o_spi_clock_in(sp[4]), .o_spi_slave_data_in(sp[5]),
    .o_spi_master_data_in(sp[6]), .o_spi_slave_select_in(sp[7]),
    .o_ext_irq1_in(sp[8]));
  paf_pad_model u_paf_pad_model (.i_ref_clk(clk), .i_drive_en(de),
    .i_drive_val(dv), .i_pullup(pu), .i_ext_en(xe), .i_ext_val(xv),
    .o_pad(pad));
  task automatic model();
    logic       sm, tw, ms, global_pullup_disable;
    logic [7:0] dd, vv, pt;
    sm = c[2] & c[3];
    tw = c[8] & c[7];
    ms = tw & c[9];
    global_pullup_disable = c[0] | c[1];
    dd = dir;
    vv = outb;
    pt = 8'h00;
    epu = ~dir & outb & {8{~global_pullup_disable}};
    if (c[14] | c[16]) begin
      dd[0] = 1'b0;
      epu[0] = outb[0] & ~global_pullup_disable;
    end
    if (c[15] | c[17]) dd[1] = 1'b1;
    if (c[17]) vv[1] = c[18];
    if (sm) vv[2] = c[4];
    else if (ms) vv[2] = c[10];
    else if (c[19]) vv[2] = c[20];
    if (sm | tw) dd[5] = (c[13] | outb[5]) & dir[6];
    if (sm) begin
      epu = epu & 8'h8B | outb & 8'h74 & {8{~global_pullup_disable}};
      dd[2] = 1'b0;
      dd[6] = 1'b0;
      dd[4] = 1'b1;
      vv[4] = c[5];
      vv[5] = c[6];
    end else if (tw) begin
      if (dir[4]) vv[4] = 1'b0;
      if (dir[5]) vv[5] = 1'b0;
    end
    pt[5] = c[12] & c[7];
    epu = epu & ~dd;
    ed = dd & ~(pt & vv);
    ev = vv;
    ien = ~adc | msk & {8{c[22]}};
    ien[3] = ien[3] | c[21];
    ien[5:4] = ien[5:4] | {2{c[11] & c[7]}};
    pe = ed & ev | ~ed & (xe & xv | ~xe & epu);
    km = ed | xe | epu;
  endtask
  task automatic chk(input logic [7:0] e, input logic [7:0] a);
    check_count++;
    if (a !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask
  task close_out();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      close_out();
    end
  end
  initial begin
    t = $urandom(32'h6878804b);
    repeat (8) @(posedge clk);
    #2 rst = 1'b0;
    for (int ph = 0; ph < 2; ph++) begin
      for (t = 0; t < 300; t++) begin
        @(posedge clk);
        #2 {dir, outb, msk, adc} = $urandom;
        {xe, xv} = 16'($urandom);
        c = 23'($urandom);
        repeat (6) @(posedge clk);
        #2 model();
        chk(ed, de);
        chk(ev, dv);
        chk(epu, pu);
        chk(ien, ie);
        chk(pe & ien & km, pcs & km);
        chk({8{km[5]}} & {5'h00, {3{pe[5] & ien[5]}}},
            {8{km[5]}} & {5'h00, sp[0], sp[2], sp[4]});
        chk({8{km[4]}} & {5'h00, {3{pe[4] & ien[4]}}},
            {8{km[4]}} & {5'h00, sp[1], sp[3], sp[5]});
        chk(pe & ien & km & 8'h4C, km & {1'b0, sp[7], 2'h0, sp[8],
            sp[6], 2'h0});
      end
      $display("test %0d random override vectors done", ph);
      @(posedge clk);
      #2 rst = 1'b1;
      @(posedge clk);
      #2 chk(8'h00, de | dv | pu | ie);
      chk(8'h00, pcs | sp[7:0] | {7'h00, sp[8]});
      rst = 1'b0;
      $display("test %0d mid-run reset done", ph);
    end
    close_out();
  end
endmodule
